// *** design/sub_idle_pkg.sv ***
// sub-idle standby controller: shared constants, states and carriers
// assumes one system clock; register map is a plain 8-bit port
package sub_idle_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    ////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_POWER_SAVE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_POWER_SAVE_MODE_SELECT = 8'h04;
    localparam logic [7:0] OFS_NOISE_FILTER_CONTROL = 8'h08;
    localparam logic [7:0] OFS_MULTIPLIER_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_NMI_WAKE_MASK_ZERO = 1;
    localparam int BIT_NMI_WAKE_MASK_ONE = 2;
    localparam int BIT_MASKABLE_WAKE_MASK = 4;
    localparam int BIT_STANDBY_STOP_TRIGGER = 7;
    localparam int BIT_NF_ENABLE = 7;
    localparam int NF_SEL_LSB = 0;
    localparam int NF_SEL_W = 3;
    localparam int BIT_MULTIPLIER_ENABLE = 0;
    localparam int BIT_MAIN_CLOCK_STOP = 0;
    localparam int BIT_SUBCLOCK_MODE = 1;
    localparam int BIT_WATCH_ON_SUBCLOCK = 2;
    localparam int BIT_WDT_ON_INTERNAL_OSC = 3;
    localparam int CSI_EXT_LSB = 4;
    localparam int BIT_UART0_EXT_BAUD = 7;
    localparam int BIT_ST_IDLE = 0;
    localparam int BIT_ST_WAKING = 1;
    localparam int BIT_ST_LAST_NMI = 2;
    localparam int BIT_ST_LAST_ACK = 3;

    ////////////////////////////////////////////////////////////////////
    // values and reset values
    localparam logic [1:0] MODE_SUB_IDLE = 2'h2;
    localparam logic [2:0] NF_SEL_SLOW_MIN = 3'h2;
    localparam logic [7:0] SAVE_CTL_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] FILT_CTL_RESET = 8'h00;
    localparam logic [7:0] MULT_RESET = 8'h00;
    localparam logic [7:0] CLKCFG_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned WAKE_SUBCLK_CYCLES = 12;
    localparam int unsigned WAKE_TIME_US = 366;

    typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_WAKE} pm_state_t;

    typedef struct packed {
        logic cpu;
        logic dma;
        logic intc;
        logic timer_pq;
        logic watch;
        logic wdt;
        logic [2:0] csi;
        logic [3:0] uart;
        logic adc_run;
        logic key_irq;
        logic port_hold;
        logic data_hold;
    } run_en_t;

endpackage

// *** design/wake_latency_counter.sv ***
// wake latency counter: counts subclock rising edges after a start pulse
// assumes subclk_in is an asynchronous pin, slower than the system clock
module wake_latency_counter #(
    parameter int unsigned CYCLES = 12
) (
    input wire logic clk_sys_in, // system clock
    input wire logic rst_b_in, // async reset, active low
    input wire logic subclk_in, // subclock pin
    input wire logic start_in, // begin a wait, ignored while busy
    output logic busy_out, // wait in progress
    output logic done_out // one-cycle pulse at expiry
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

    if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
        $error("wake_latency_counter: CYCLES out of range");
    end

    logic sub_s1_q, sub_s2_q, sub_s3_q;
    logic busy_q, done_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] seen_q;
    logic edge_w;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else begin
            sub_s1_q <= subclk_in;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    assign edge_w = sub_s2_q & ~sub_s3_q;

    // counted on the subclock, so the latency is independent of fclk
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q) begin
                busy_q <= start_in;
                cnt_q <= '0;
            end else if (edge_w) begin
                if (cnt_q == CNT_LAST) begin // RULE_03 RULE_24
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;

    // independent edge tally for the latency check
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            seen_q <= '0;
        end else if (!busy_q) begin
            seen_q <= '0;
        end else if (edge_w) begin
            seen_q <= seen_q + 1'b1;
        end
    end

    chk_latency_exact: assert property ( // RULE_03
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        done_q |-> $past(seen_q) == CNT_W'(CYCLES - 1) && !busy_q)
        else $error("wake released after wrong subclock count");

endmodule

// *** design/sub_idle_ctrl.sv ***
// sub-idle standby controller: entry, wake qualification, latency,
// peripheral run enables and wake resolution for the cpu
// assumes interrupt inputs come from logic on clk_sys_in
// Contract
// [RULE_01] NMI or unmasked maskable request wakes
// [RULE_02] masked requests never end sub-idle
// [RULE_03] exit completes twelve subclock cycles after request
// [RULE_04] slow-filtered pin three cannot wake
// [RULE_05] lower priority in service: wake, no ack
// [RULE_06] higher priority or NMI: wake and ack
// [RULE_07] NMI wake always branches to handler
// [RULE_08] maskable wake, interrupts off: next instruction
// [RULE_09] reset release equals ordinary reset
// [RULE_10] cpu, dma, intc halted; wake detect kept
// [RULE_11] timer groups P and Q stopped
// [RULE_12] watch timer runs only main-stopped on subclock
// [RULE_13] watchdog two runs only on internal oscillator
// [RULE_14] clocked serial runs only on external clock
// [RULE_15] async serial stops except channel zero external
// [RULE_16] adc frozen, result kept
// [RULE_17] port pins hold entry state
// [RULE_18] internal data preserved unchanged
// [RULE_19] software clears multiplier before main stop
// [RULE_20] key input interrupt stays operable
// [RULE_21] software enters via mode ten then stop
// [RULE_22] interrupt wake resumes subclock mode
// [RULE_23] pending unmasked request exits immediately
// [RULE_24] subclock counter times wake, opens cpu gate
module sub_idle_ctrl #(
    parameter int unsigned WAKE_CYCLES = sub_idle_pkg::WAKE_SUBCLK_CYCLES
) (
    input wire logic clk_sys_in, // system clock, 50 MHz
    input wire logic rst_b_in, // async reset, active low
    input wire logic [sub_idle_pkg::ADDR_W-1:0] reg_addr_in, // reg address
    input wire logic [sub_idle_pkg::DATA_W-1:0] reg_wdata_in, // write data
    input wire logic reg_wr_in, // write strobe
    input wire logic reg_rd_in, // read strobe
    output logic [sub_idle_pkg::DATA_W-1:0] reg_rdata_out, // read data
    input wire logic subclk_in, // subclock pin
    input wire logic [1:0] nmi_req_in, // non-maskable sources 0, 1
    input wire logic irq_req_in, // unmasked maskable request
    input wire logic irq_pin3_req_in, // external pin three request
    input wire logic in_service_in, // cpu inside a service routine
    input wire logic irq_higher_in, // request outranks one in service
    input wire logic global_irq_on_in, // interrupts globally enabled
    output sub_idle_pkg::run_en_t periph_run_out, // run enables
    output logic multiplier_run_out, // frequency multiplier runs
    output logic standby_out, // sub-idle or waking
    output logic wake_done_out, // pulse: cpu released
    output logic wake_ack_out, // pulse: request acknowledged
    output logic wake_branch_out, // pulse: branch to handler
    output logic wake_next_out // pulse: continue next instruction
);
    import sub_idle_pkg::*;

    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255) begin : g_bad_wake
        $error("sub_idle_ctrl: WAKE_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] pwr_ctl_q;
    logic [1:0] mode_q;
    logic [7:0] filt_ctl_q;
    logic [7:0] mult_q;
    logic [7:0] clkcfg_q;
    logic [7:0] rdata_q;
    logic [7:0] status_w, rdata_d;
    logic wr_ctl_w, enter_req_w;

    assign wr_ctl_w = reg_wr_in && reg_addr_in == OFS_POWER_SAVE_CONTROL;
    assign enter_req_w = wr_ctl_w && reg_wdata_in[BIT_STANDBY_STOP_TRIGGER]
        && mode_q == MODE_SUB_IDLE // RULE_21
        && clkcfg_q[BIT_SUBCLOCK_MODE];

    // reset puts every register back at its power-on value
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin // RULE_09
            pwr_ctl_q <= SAVE_CTL_RESET;
            mode_q <= MODE_RESET;
            filt_ctl_q <= FILT_CTL_RESET;
            mult_q <= MULT_RESET;
            clkcfg_q <= CLKCFG_RESET;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_POWER_SAVE_CONTROL: begin
                    // stop trigger self clears; every other bit is stored as written
                    pwr_ctl_q <= reg_wdata_in &
                        ~(8'h01 << BIT_STANDBY_STOP_TRIGGER);
                end
                OFS_POWER_SAVE_MODE_SELECT: mode_q <= reg_wdata_in[1:0];
                OFS_NOISE_FILTER_CONTROL: filt_ctl_q <= reg_wdata_in;
                OFS_MULTIPLIER_CONTROL: mult_q <= reg_wdata_in;
                OFS_CLOCK_CONFIG: clkcfg_q <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wake qualification

    logic nmi_wake_w, pin3_blocked_w, mask_wake_w, wake_req_w;

    assign nmi_wake_w =
        (nmi_req_in[0] && !pwr_ctl_q[BIT_NMI_WAKE_MASK_ZERO]) || // RULE_02
        (nmi_req_in[1] && !pwr_ctl_q[BIT_NMI_WAKE_MASK_ONE]);
    // slow sampling clocks do not run in sub-idle, so the filter
    // output never changes and the pin cannot wake the device
    assign pin3_blocked_w = filt_ctl_q[BIT_NF_ENABLE] &&
        filt_ctl_q[NF_SEL_LSB +: NF_SEL_W] >= NF_SEL_SLOW_MIN; // RULE_04
    assign mask_wake_w = !pwr_ctl_q[BIT_MASKABLE_WAKE_MASK] && // RULE_02
        (irq_req_in || (irq_pin3_req_in && !pin3_blocked_w));
    // priority plays no part in waking
    assign wake_req_w = nmi_wake_w || mask_wake_w; // RULE_01

    ////////////////////////////////////////////////////////////////////
    // standby state machine

    pm_state_t state_q;
    logic wake_nmi_q;
    logic cnt_start_w;
    logic cnt_done_w;
    logic resolve_w;

    assign cnt_start_w = state_q == ST_IDLE && wake_req_w;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    // a pending request cancels entry at once
                    if (enter_req_w && !wake_req_w) begin // RULE_23
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (wake_req_w) begin // RULE_01
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (cnt_done_w) begin // RULE_22 RULE_24
                        state_q <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // remembers whether a non-maskable source caused the wake
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_nmi_q <= 1'b0;
        end else if (cnt_start_w) begin
            wake_nmi_q <= nmi_wake_w;
        end else if (state_q == ST_RUN && enter_req_w && wake_req_w) begin
            wake_nmi_q <= nmi_wake_w;
        end
    end

    wake_latency_counter #(
        .CYCLES(WAKE_CYCLES)
    ) u_latency (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .subclk_in(subclk_in),
        .start_in(cnt_start_w),
        .busy_out(),
        .done_out(cnt_done_w)
    );

    ////////////////////////////////////////////////////////////////////
    // wake resolution towards the cpu

    logic ack_d, branch_d;
    logic done_q, ack_q, branch_q, next_q;
    logic last_ack_q;
    logic imm_nmi_w;

    assign imm_nmi_w = enter_req_w && state_q == ST_RUN && nmi_wake_w;
    assign resolve_w = (state_q == ST_WAKE && cnt_done_w) ||
        (state_q == ST_RUN && enter_req_w && wake_req_w);

    always_comb begin
        ack_d = 1'b0;
        branch_d = 1'b0;
        if (wake_nmi_q && state_q == ST_WAKE || imm_nmi_w) begin
            ack_d = 1'b1; // RULE_06
            branch_d = 1'b1; // RULE_07
        end else if (global_irq_on_in) begin
            // a lower level request stays pending in the controller
            ack_d = !in_service_in || irq_higher_in; // RULE_05 RULE_06
            branch_d = ack_d;
        end
        // with interrupts off a maskable wake always runs the next instruction
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_q <= 1'b0;
            ack_q <= 1'b0;
            branch_q <= 1'b0;
            next_q <= 1'b0;
            last_ack_q <= 1'b0;
        end else begin
            done_q <= resolve_w;
            ack_q <= resolve_w && ack_d;
            branch_q <= resolve_w && branch_d;
            next_q <= resolve_w && !branch_d; // RULE_08
            if (resolve_w) begin
                last_ack_q <= ack_d;
            end
        end
    end

    assign wake_done_out = done_q;
    assign wake_ack_out = ack_q;
    assign wake_branch_out = branch_q;
    assign wake_next_out = next_q;

    ////////////////////////////////////////////////////////////////////
    // run enables for the rest of the chip

    logic idle_w;
    logic main_stop_w;
    run_en_t run_d;
    run_en_t run_q;
    logic mult_run_q;

    assign idle_w = state_q != ST_RUN;
    assign main_stop_w = clkcfg_q[BIT_MAIN_CLOCK_STOP];

    always_comb begin
        run_d.cpu = !idle_w; // RULE_10
        run_d.dma = !idle_w; // RULE_10
        run_d.intc = !idle_w; // RULE_10
        run_d.timer_pq = !idle_w; // RULE_11
        run_d.watch = !idle_w ||
            (main_stop_w && clkcfg_q[BIT_WATCH_ON_SUBCLOCK]); // RULE_12
        run_d.wdt = !idle_w || clkcfg_q[BIT_WDT_ON_INTERNAL_OSC]; // RULE_13
        run_d.csi = {3{!idle_w}} |
            clkcfg_q[CSI_EXT_LSB +: 3]; // RULE_14
        run_d.uart = {{3{!idle_w}},
            !idle_w || clkcfg_q[BIT_UART0_EXT_BAUD]}; // RULE_15
        run_d.adc_run = !idle_w; // RULE_16
        run_d.key_irq = 1'b1; // RULE_20
        run_d.port_hold = idle_w; // RULE_17
        run_d.data_hold = idle_w; // RULE_18
    end

    // registered so that no gate enable glitches while decoding
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_q <= '0;
            mult_run_q <= 1'b0;
        end else begin
            run_q <= run_d;
            // forced off by main clock stop, whatever software leaves in the enable
            mult_run_q <= mult_q[BIT_MULTIPLIER_ENABLE] &&
                !main_stop_w; // RULE_19
        end
    end

    assign periph_run_out = run_q;
    assign multiplier_run_out = mult_run_q;
    assign standby_out = idle_w;

    ////////////////////////////////////////////////////////////////////
    // register read port

    always_comb begin
        status_w = 8'h00;
        status_w[BIT_ST_IDLE] = state_q == ST_IDLE;
        status_w[BIT_ST_WAKING] = state_q == ST_WAKE;
        status_w[BIT_ST_LAST_NMI] = wake_nmi_q;
        status_w[BIT_ST_LAST_ACK] = last_ack_q;
        rdata_d = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_POWER_SAVE_CONTROL: rdata_d = pwr_ctl_q;
                OFS_POWER_SAVE_MODE_SELECT: rdata_d = {6'h00, mode_q};
                OFS_NOISE_FILTER_CONTROL: rdata_d = filt_ctl_q;
                OFS_MULTIPLIER_CONTROL: rdata_d = mult_q;
                OFS_CLOCK_CONFIG: rdata_d = clkcfg_q;
                OFS_STATUS: rdata_d = status_w;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_nmi_wakes_idle: assert property ( // RULE_01
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_IDLE && nmi_wake_w |=> state_q == ST_WAKE)
        else $error("unmasked nmi did not start wake");

    chk_masked_no_wake: assert property ( // RULE_02
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_IDLE && pwr_ctl_q[BIT_MASKABLE_WAKE_MASK] &&
        pwr_ctl_q[BIT_NMI_WAKE_MASK_ZERO] && pwr_ctl_q[BIT_NMI_WAKE_MASK_ONE]
        |=> state_q == ST_IDLE)
        else $error("masked request left sub-idle");

    chk_pin3_filtered: assert property ( // RULE_04
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_IDLE && pin3_blocked_w && !irq_req_in &&
        !nmi_wake_w |=> state_q == ST_IDLE)
        else $error("filtered pin three woke the device");

    chk_low_pri_pending: assert property ( // RULE_05
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        resolve_w && !wake_nmi_q && !imm_nmi_w && in_service_in &&
        !irq_higher_in |=> wake_done_out && !wake_ack_out)
        else $error("lower priority request was acknowledged");

    chk_nmi_branch: assert property ( // RULE_07
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_WAKE && cnt_done_w && wake_nmi_q
        |=> wake_ack_out && wake_branch_out && !wake_next_out)
        else $error("nmi wake did not branch");

    chk_di_next: assert property ( // RULE_08
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_WAKE && cnt_done_w && !wake_nmi_q &&
        !global_irq_on_in |=> wake_next_out && !wake_branch_out)
        else $error("maskable wake with interrupts off branched");

    chk_cpu_halted: assert property ( // RULE_10
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_IDLE ##1 state_q == ST_IDLE
        |-> !periph_run_out.cpu && !periph_run_out.dma)
        else $error("cpu or dma running in sub-idle");

    chk_timer_pq_stop: assert property ( // RULE_11
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        idle_w |=> !periph_run_out.timer_pq)
        else $error("timer groups ran in sub-idle");

    chk_watch_gate: assert property ( // RULE_12
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        idle_w && !main_stop_w |=> !periph_run_out.watch)
        else $error("watch timer ran with main clock on");

    chk_port_hold: assert property ( // RULE_17
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(idle_w) |=> periph_run_out.port_hold [*2])
        else $error("ports not held in sub-idle");

    chk_stay_subclock: assert property ( // RULE_22
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_WAKE && cnt_done_w && !reg_wr_in
        |=> clkcfg_q[BIT_SUBCLOCK_MODE] && state_q == ST_RUN)
        else $error("wake left subclock mode");

    chk_pending_exit: assert property ( // RULE_23
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        state_q == ST_RUN && enter_req_w && wake_req_w
        |=> state_q == ST_RUN && wake_done_out)
        else $error("pending request did not cancel entry");

endmodule

// *** test/sub_idle_partner.sv ***
// partner: subclock oscillator and interrupt sources seen by the controller
// assumes requests are synchronous to clk_sys_in
module sub_idle_partner (
    input wire logic clk_sys_in, // system clock
    input wire logic rst_b_in, // async reset, active low
    input wire logic [2:0] fire_in, // raise nmi1, nmi0, irq
    input wire logic done_in, // cpu released
    output logic subclk_out, // free-running subclock
    output logic [1:0] nmi_out, // nmi levels
    output logic irq_out // maskable level
);
    timeunit 1ns;
    timeprecision 1ns;

    // oscillator keeps running in sub-idle, unrelated phase
    initial begin
        subclk_out = 1'b0;
        #7;
        forever #100 subclk_out = ~subclk_out;
    end

    // a request holds until the cpu is released, then counts as served
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {nmi_out, irq_out} <= 3'h0;
        end else if (done_in) begin
            {nmi_out, irq_out} <= 3'h0;
        end else begin
            {nmi_out, irq_out} <= {nmi_out, irq_out} | fire_in;
        end
    end
endmodule

// *** test/sub_idle_ctrl_bench.sv ***
// bench: register access, blocked wakes, random wakes, pending exit
// assumes sub_idle_partner supplies subclock and request levels
module sub_idle_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sub_idle_pkg::*;
    logic clk_sys_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic pin3 = 1'b0, svc = 1'b0, hi = 1'b0, irq_on = 1'b0;
    logic subclk, irq, mult, stby, done, ack, br, nx;
    logic [1:0] nmi;
    logic [2:0] fire = 3'h0;
    run_en_t run;
    int fail_count = 0, checked = 0, n, k;

    always #10 clk_sys_in = ~clk_sys_in;

    sub_idle_ctrl dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .subclk_in(subclk),
        .nmi_req_in(nmi), .irq_req_in(irq), .irq_pin3_req_in(pin3),
        .in_service_in(svc), .irq_higher_in(hi), .global_irq_on_in(irq_on),
        .periph_run_out(run), .multiplier_run_out(mult),
        .standby_out(stby), .wake_done_out(done), .wake_ack_out(ack),
        .wake_branch_out(br), .wake_next_out(nx));
    sub_idle_partner part_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .fire_in(fire), .done_in(done), .subclk_out(subclk),
        .nmi_out(nmi), .irq_out(irq));

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrt(input logic [7:0] a, d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, e);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask

    // nmi always served; maskable served only if enabled and nothing in service or outranking
    function automatic logic [2:0] resolve(logic is_nmi, e, s, h);
        return (is_nmi || (e && (!s || h))) ? 3'b110 : 3'b001;
    endfunction

    task automatic enter(input logic [7:0] m);
        wrt(OFS_POWER_SAVE_MODE_SELECT, 8'h02);
        wrt(OFS_CLOCK_CONFIG, 8'h0A);
        wrt(OFS_POWER_SAVE_CONTROL, 8'h80 | m);
        @(posedge clk_sys_in);
        #1 chk("standby", 8'h01, {7'h0, stby});
        chk("gates", 8'h03, {3'h0, run.cpu, run.dma, run.timer_pq,
            run.wdt, run.key_irq});
    endtask

    task automatic wdone();
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge clk_sys_in);
            #1 n++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        #200_000;
        fail_count++;
        final_report();
    end

    initial begin
        void'($urandom(32'h711340b6));
        repeat (2) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        rdc(OFS_POWER_SAVE_CONTROL, SAVE_CTL_RESET);
        rdc(OFS_STATUS, 8'h00);
        rdc(8'hFF, 8'h00);
        wrt(OFS_POWER_SAVE_CONTROL, 8'h96);
        rdc(OFS_POWER_SAVE_CONTROL, 8'h16); // stop trigger reads back 0
        wrt(OFS_MULTIPLIER_CONTROL, 8'h01);
        @(posedge clk_sys_in);
        #1 chk("mult on", 8'h01, {7'h0, mult});
        wrt(OFS_MULTIPLIER_CONTROL, 8'h00);
        wrt(OFS_CLOCK_CONFIG, 8'h01);
        @(posedge clk_sys_in);
        #1 chk("mult off", 8'h00, {7'h0, mult});
        // masked request, then slow-filtered pin three: neither wakes
        for (int i = 0; i < 2; i++) begin
            if (i == 1) wrt(OFS_NOISE_FILTER_CONTROL, 8'h82);
            enter(i == 0 ? 8'h16 : 8'h00);
            if (i == 0) fire <= 3'h7;
            else pin3 <= 1'b1;
            @(posedge clk_sys_in);
            fire <= 3'h0;
            repeat (250) @(posedge clk_sys_in);
            #1 chk("blocked", 8'h01, {7'h0, stby});
            rst_b_in <= 1'b0;
            @(posedge clk_sys_in);
            #1 chk("rst standby", 8'h00, {7'h0, stby});
            rst_b_in <= 1'b1;
            pin3 <= 1'b0;
            rdc(OFS_POWER_SAVE_CONTROL, SAVE_CTL_RESET);
        end
        for (int i = 0; i < 8; i++) begin
            k = (i < 3) ? i : $urandom_range(2, 0);
            irq_on <= (i == 0) ? 1'b0 : 1'($urandom());
            svc <= 1'($urandom());
            hi <= 1'($urandom());
            enter(8'h00);
            fire <= 3'h1 << k;
            @(posedge clk_sys_in);
            fire <= 3'h0;
            wdone();
            chk("latency", 8'h01, {7'h0, n >= 110 && n <= 136});
            chk("resolve", {5'h0, resolve(k != 0, irq_on, svc, hi)},
                {5'h0, ack, br, nx});
            chk("exit", 8'h00, {7'h0, stby});
            @(posedge clk_sys_in);
            #1 chk("cpu run", 8'h01, {7'h0, run.cpu});
            rdc(OFS_CLOCK_CONFIG, 8'h0A);
        end
        fire <= 3'h1;
        @(posedge clk_sys_in);
        fire <= 3'h0;
        wrt(OFS_POWER_SAVE_CONTROL, 8'h80);
        // the done pulse stands only in the cycle after the entry write
        #1 chk("pending", 8'h01, {6'h0, stby, done});
        final_report();
    end
endmodule
